// [shared/csfb_params.svh]
// constants for the status flags and banked data memory block
`ifndef CSFB_PARAMS_SVH
`define CSFB_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// widths
`define CSFB_ADDR_W        16
`define CSFB_DATA_W        8
`define CSFB_BANK_W        5
`define CSFB_LOCAL_W       7
`define CSFB_RAM_ADDR_W    12
`define CSFB_PERIPH_ADDR_W 12

////////////////////////////////////////////////////////////////////////////
// data memory geometry
`define CSFB_BANKS         32
`define CSFB_BANK_BYTES    128
`define CSFB_CORE_REGS     12
`define CSFB_PERIPH_BYTES  20
`define CSFB_GPR_BYTES     80
`define CSFB_COMMON_BYTES  16
`define CSFB_RAM_DEPTH     (`CSFB_BANKS * `CSFB_GPR_BYTES + `CSFB_COMMON_BYTES)

////////////////////////////////////////////////////////////////////////////
// local addresses inside one bank
`define CSFB_STATUS_LOCAL  7'h03
`define CSFB_BSEL_LOCAL    7'h08
`define CSFB_CORE_LAST     7'h0B
`define CSFB_PERIPH_FIRST  7'h0C
`define CSFB_PERIPH_LAST   7'h1F
`define CSFB_GPR_FIRST     7'h20
`define CSFB_GPR_LAST      7'h6F
`define CSFB_COMMON_FIRST  7'h70

////////////////////////////////////////////////////////////////////////////
// bus address regions
`define CSFB_REGION_ABS    4'h0
`define CSFB_REGION_BANKED 4'h1
`define CSFB_BANKED_HI     5'h00
`define CSFB_LINEAR_BASE   16'h2000
`define CSFB_LINEAR_LAST   16'h29FF
`define CSFB_COMMON_BASE   12'hA00

////////////////////////////////////////////////////////////////////////////
// bus address and operand field positions
`define CSFB_REGION_W      4
`define CSFB_REGION_LO     12
`define CSFB_BANK_LO       7
`define CSFB_NIB_W         4

////////////////////////////////////////////////////////////////////////////
// status register bit positions and reset values
`define CSFB_BIT_WDT       4
`define CSFB_BIT_SLEEP     3
`define CSFB_BIT_Z         2
`define CSFB_BIT_DC        1
`define CSFB_BIT_C         0
`define CSFB_UNUSED_BITS   3'h0
`define CSFB_POR_HI_FLAG   1'b1
`define CSFB_POR_ARITH     1'b0
`define CSFB_BSEL_RESET    5'h00
`define CSFB_BSEL_PAD      3'h0
`define CSFB_ZERO_BYTE     8'h00

`endif

// [shared/csfb_pkg.sv]
// types shared by the status flags and banked data memory block
package csfb_pkg;

  // operation presented by the execution core
  typedef enum logic [1:0] {
    csfb_op_none,
    csfb_op_add,
    csfb_op_sub,
    csfb_op_logic
  } csfb_alu_op_t;

  // target of one bus access
  typedef enum logic [2:0] {
    csfb_area_none,
    csfb_area_status,
    csfb_area_bsel,
    csfb_area_periph,
    csfb_area_ram
  } csfb_area_t;

endpackage : csfb_pkg

// [logic/csfb_ram.sv]
// byte memory for general and common ram, registered read data
`include "csfb_params.svh"

module csfb_ram #(
  parameter int DATA_W = `CSFB_DATA_W,
  parameter int DEPTH  = `CSFB_RAM_DEPTH,
  parameter int ADDR_W = `CSFB_RAM_ADDR_W
) (
  input  wire logic              sys_clk,
  input  wire logic              clk_en,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem_q [DEPTH];

  // store a byte
  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem_q[addr] <= wdata;
    end
  end

  // read out through a register
  always_ff @(posedge sys_clk) begin
    if (clk_en && rd_en) begin
      rdata <= mem_q[addr];
    end
  end

endmodule // csfb_ram

// [logic/csfb_status_banks.sv]
// status flags, bank selector and banked data memory decode
`include "csfb_params.svh"

module csfb_status_banks #(
  parameter int ADDR_W = `CSFB_ADDR_W,
  parameter int DATA_W = `CSFB_DATA_W
) (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  input  wire logic                          soft_rst,
  input  wire logic [ADDR_W-1:0]             bus_addr,
  input  wire logic [DATA_W-1:0]             bus_wdata,
  input  wire logic                          bus_wr,
  input  wire logic                          bus_rd,
  output logic      [DATA_W-1:0]             bus_rdata,
  input  wire csfb_pkg::csfb_alu_op_t        alu_op,
  input  wire logic [DATA_W-1:0]             alu_a,
  input  wire logic [DATA_W-1:0]             alu_b,
  input  wire logic [DATA_W-1:0]             alu_logic_result,
  output logic      [DATA_W-1:0]             alu_result_q,
  output logic                               flags_updated_q,
  input  wire logic                          watchdog_kick_instr,
  input  wire logic                          sleep_instr,
  input  wire logic                          watchdog_timeout,
  output logic      [DATA_W-1:0]             status_flags,
  output logic      [`CSFB_BANK_W-1:0]       bank_selector_q,
  output logic      [`CSFB_PERIPH_ADDR_W-1:0] periph_addr,
  output logic      [DATA_W-1:0]             periph_wdata,
  output logic                               periph_wr,
  output logic                               periph_rd,
  input  wire logic [DATA_W-1:0]             periph_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                          flag_z_q;
  logic                          flag_c_q;
  logic                          nibble_overflow_flag_q;
  logic                          watchdog_expiry_flag_n_q;
  logic                          sleep_entered_flag_n_q;
  logic                          flag_z_d;
  logic                          flag_c_d;
  logic                          nibble_overflow_flag_d;

  logic [`CSFB_BANK_W-1:0]       acc_bank;
  logic [`CSFB_LOCAL_W-1:0]      acc_local;
  logic                          acc_banked;
  csfb_pkg::csfb_area_t          acc_area;
  logic [`CSFB_RAM_ADDR_W-1:0]   ram_addr;
  logic [ADDR_W-1:0]             lin_offset;

  // address fields
  logic [`CSFB_REGION_W-1:0]     addr_region;
  logic [`CSFB_BANK_W-1:0]       addr_bank;
  logic [`CSFB_LOCAL_W-1:0]      addr_local;

  logic                          ram_wr;
  logic                          ram_rd;
  logic [DATA_W-1:0]             ram_rdata;
  logic                          status_wr;
  logic                          bsel_wr;

  csfb_pkg::csfb_area_t          rd_area_q;
  logic [DATA_W-1:0]             rd_reg_q;
  logic [DATA_W-1:0]             reg_rdata;

  logic                          is_arith;
  logic                          is_sub;
  logic                          is_op;
  logic [DATA_W-1:0]             b_eff;
  logic [DATA_W:0]               sum_full;
  logic [`CSFB_NIB_W:0]          nib_sum;
  logic [DATA_W-1:0]             op_result;
  logic                          live;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic unit

  // operation class and subtract operand
  assign is_arith = (alu_op == csfb_pkg::csfb_op_add) ||
                    (alu_op == csfb_pkg::csfb_op_sub);
  assign is_sub   = (alu_op == csfb_pkg::csfb_op_sub);
  assign is_op    = (alu_op != csfb_pkg::csfb_op_none);
  assign live     = clk_en && !soft_rst;
  assign b_eff    = is_sub ? ~alu_b : alu_b;

  // full sum and low nibble sum, carry-in one when subtracting
  assign sum_full = {1'b0, alu_a} + {1'b0, b_eff} +
                    {{DATA_W{1'b0}}, is_sub};
  assign nib_sum  = {1'b0, alu_a[`CSFB_NIB_W-1:0]} +
                    {1'b0, b_eff[`CSFB_NIB_W-1:0]} +
                    {{`CSFB_NIB_W{1'b0}}, is_sub};

  // result that feeds the zero test
  assign op_result = is_arith ? sum_full[DATA_W-1:0] : alu_logic_result;

  // result register for the core
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alu_result_q <= `CSFB_ZERO_BYTE;
    end else if (live && is_op) begin
      alu_result_q <= op_result;
    end
  end

  // one-cycle pulse after an operation is taken
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_updated_q <= 1'b0;
    end else if (clk_en) begin
      flags_updated_q <= live && is_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // bus address fields
  assign addr_region = bus_addr[`CSFB_REGION_LO +: `CSFB_REGION_W];
  assign addr_bank   = bus_addr[`CSFB_BANK_LO +: `CSFB_BANK_W];
  assign addr_local  = bus_addr[`CSFB_LOCAL_W-1:0];

  // split the bus address into bank and local, or a linear ram index
  always_comb begin
    acc_bank   = `CSFB_BSEL_RESET;
    acc_local  = {`CSFB_LOCAL_W{1'b0}};
    acc_banked = 1'b0;
    lin_offset = bus_addr - `CSFB_LINEAR_BASE;
    acc_area   = csfb_pkg::csfb_area_none;
    ram_addr   = {`CSFB_RAM_ADDR_W{1'b0}};
    if (addr_region == `CSFB_REGION_ABS) begin
      acc_bank   = addr_bank;
      acc_local  = addr_local;
      acc_banked = 1'b1;
    end else if (addr_region == `CSFB_REGION_BANKED &&
                 addr_bank == `CSFB_BANKED_HI) begin
      acc_bank   = bank_selector_q;
      acc_local  = addr_local;
      acc_banked = 1'b1;
    end else if (bus_addr >= `CSFB_LINEAR_BASE &&
                 bus_addr <= `CSFB_LINEAR_LAST) begin
      acc_area = csfb_pkg::csfb_area_ram;
      ram_addr = lin_offset[`CSFB_RAM_ADDR_W-1:0];
    end
    // local offset picks the target inside the chosen bank
    if (acc_banked) begin
      if (acc_local == `CSFB_STATUS_LOCAL) begin
        acc_area = csfb_pkg::csfb_area_status;
      end else if (acc_local == `CSFB_BSEL_LOCAL) begin
        acc_area = csfb_pkg::csfb_area_bsel;
      end else if (acc_local <= `CSFB_CORE_LAST) begin
        acc_area = csfb_pkg::csfb_area_none;
      end else if (acc_local <= `CSFB_PERIPH_LAST) begin
        acc_area = csfb_pkg::csfb_area_periph;
      end else if (acc_local <= `CSFB_GPR_LAST) begin
        acc_area = csfb_pkg::csfb_area_ram;
        ram_addr = `CSFB_RAM_ADDR_W'(acc_bank * `CSFB_GPR_BYTES) +
                   `CSFB_RAM_ADDR_W'(acc_local - `CSFB_GPR_FIRST);
      end else begin
        acc_area = csfb_pkg::csfb_area_ram;
        ram_addr = `CSFB_COMMON_BASE +
                   `CSFB_RAM_ADDR_W'(acc_local - `CSFB_COMMON_FIRST);
      end
    end
  end

  // strobes per target
  // soft reset drops ram and peripheral writes; reads carry on
  assign status_wr = bus_wr && (acc_area == csfb_pkg::csfb_area_status);
  assign bsel_wr   = bus_wr && (acc_area == csfb_pkg::csfb_area_bsel);
  assign ram_wr    = live && bus_wr && (acc_area == csfb_pkg::csfb_area_ram);
  assign ram_rd    = bus_rd && (acc_area == csfb_pkg::csfb_area_ram);

  // peripheral control area forwarding
  assign periph_addr  = {acc_bank, acc_local};
  assign periph_wdata = bus_wdata;
  assign periph_wr    = live && bus_wr &&
                        (acc_area == csfb_pkg::csfb_area_periph);
  assign periph_rd    = clk_en && bus_rd &&
                        (acc_area == csfb_pkg::csfb_area_periph);

  ////////////////////////////////////////////////////////////////////////////
  // general and common ram

  csfb_ram #(
    .DATA_W (DATA_W),
    .DEPTH  (`CSFB_RAM_DEPTH),
    .ADDR_W (`CSFB_RAM_ADDR_W)
  ) u_ram (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .wr_en   (ram_wr),
    .rd_en   (ram_rd),
    .addr    (ram_addr),
    .wdata   (bus_wdata),
    .rdata   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic flags

  // next flag values: operation result wins over a status write
  always_comb begin
    flag_z_d               = flag_z_q;
    nibble_overflow_flag_d = nibble_overflow_flag_q;
    flag_c_d               = flag_c_q;
    if (status_wr) begin
      flag_z_d               = bus_wdata[`CSFB_BIT_Z];
      nibble_overflow_flag_d = bus_wdata[`CSFB_BIT_DC];
      flag_c_d               = bus_wdata[`CSFB_BIT_C];
    end
    if (is_op) begin
      flag_z_d = (op_result == `CSFB_ZERO_BYTE);
    end
    if (is_arith) begin
      nibble_overflow_flag_d = nib_sum[4];
      flag_c_d               = sum_full[DATA_W];
    end
  end

  // flag registers, cleared only by power or brownout reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_z_q               <= `CSFB_POR_ARITH;
      nibble_overflow_flag_q <= `CSFB_POR_ARITH;
      flag_c_q               <= `CSFB_POR_ARITH;
    end else if (live) begin
      flag_z_q               <= flag_z_d;
      nibble_overflow_flag_q <= nibble_overflow_flag_d;
      flag_c_q               <= flag_c_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause flags

  // timeout flag: expiry clears, kick or sleep sets
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      watchdog_expiry_flag_n_q <= `CSFB_POR_HI_FLAG;
    end else if (clk_en) begin
      if (watchdog_timeout) begin
        watchdog_expiry_flag_n_q <= 1'b0;
      end else if (watchdog_kick_instr || sleep_instr) begin
        watchdog_expiry_flag_n_q <= 1'b1;
      end
    end
  end

  // sleep flag: sleep clears, kick sets
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleep_entered_flag_n_q <= `CSFB_POR_HI_FLAG;
    end else if (clk_en) begin
      if (sleep_instr) begin
        sleep_entered_flag_n_q <= 1'b0;
      end else if (watchdog_kick_instr) begin
        sleep_entered_flag_n_q <= 1'b1;
      end
    end
  end

  // assembled status byte; bus writes never reach bits 7 to 3
  assign status_flags = {`CSFB_UNUSED_BITS,
                         watchdog_expiry_flag_n_q,
                         sleep_entered_flag_n_q,
                         flag_z_q,
                         nibble_overflow_flag_q,
                         flag_c_q};

  ////////////////////////////////////////////////////////////////////////////
  // bank selector

  // any reset returns to bank zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank_selector_q <= `CSFB_BSEL_RESET;
    end else if (clk_en) begin
      if (soft_rst) begin
        bank_selector_q <= `CSFB_BSEL_RESET;
      end else if (bsel_wr) begin
        bank_selector_q <= bus_wdata[`CSFB_BANK_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // value of the locally held registers
  always_comb begin
    reg_rdata = `CSFB_ZERO_BYTE;
    if (acc_area == csfb_pkg::csfb_area_status) begin
      reg_rdata = status_flags;
    end else if (acc_area == csfb_pkg::csfb_area_bsel) begin
      reg_rdata = {`CSFB_BSEL_PAD, bank_selector_q};
    end
  end

  // capture read target and register value for the next cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_area_q <= csfb_pkg::csfb_area_none;
      rd_reg_q  <= `CSFB_ZERO_BYTE;
    end else if (clk_en) begin
      rd_area_q <= bus_rd ? acc_area : csfb_pkg::csfb_area_none;
      rd_reg_q  <= bus_rd ? reg_rdata : `CSFB_ZERO_BYTE;
    end
  end

  // read data: ram, peripheral or local register, zero otherwise
  always_comb begin
    unique case (rd_area_q)
      csfb_pkg::csfb_area_ram:    bus_rdata = ram_rdata;
      csfb_pkg::csfb_area_periph: bus_rdata = periph_rdata;
      csfb_pkg::csfb_area_status,
      csfb_pkg::csfb_area_bsel:   bus_rdata = rd_reg_q;
      csfb_pkg::csfb_area_none:   bus_rdata = `CSFB_ZERO_BYTE;
      default:                    bus_rdata = `CSFB_ZERO_BYTE;
    endcase
  end

endmodule // csfb_status_banks

// [verification/csfb_status_banks_sva.sv]
// checker for the status flag and bank decode ports
`include "csfb_params.svh"

module csfb_status_banks_sva #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic                           sys_clk,
  input wire logic                           sys_rst,
  input wire logic                           clk_en,
  input wire logic                           soft_rst,
  input wire logic [ADDR_W-1:0]              bus_addr,
  input wire logic                           bus_wr,
  input wire csfb_pkg::csfb_alu_op_t         alu_op,
  input wire logic [DATA_W-1:0]              alu_a,
  input wire logic [DATA_W-1:0]              alu_b,
  input wire logic [DATA_W-1:0]              alu_result_q,
  input wire logic                           flags_updated_q,
  input wire logic                           watchdog_kick_instr,
  input wire logic                           sleep_instr,
  input wire logic                           watchdog_timeout,
  input wire logic [DATA_W-1:0]              status_flags,
  input wire logic [`CSFB_PERIPH_ADDR_W-1:0] periph_addr,
  input wire logic                           periph_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       go;
  logic       add_t;
  logic       sub_t;
  logic [8:0] s_add;
  logic [8:0] s_sub;
  logic [4:0] n_add;
  logic [4:0] n_sub;
  logic [9:0] exp_add;
  logic [9:0] exp_sub;
  // reference sums and nibble carries
  assign go = clk_en && !soft_rst;
  assign add_t = go && alu_op == csfb_pkg::csfb_op_add;
  assign sub_t = go && alu_op == csfb_pkg::csfb_op_sub;
  assign s_add = {1'b0, alu_a} + {1'b0, alu_b};
  assign s_sub = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
  assign n_add = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
  assign n_sub = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
  assign exp_add = {n_add[4], s_add};
  assign exp_sub = {n_sub[4], s_sub};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  upper_bits_a: assert property (status_flags[7:5] == 3'h0)
    else $error("unused status bits not zero");
  expiry_clear_a: assert property (clk_en && watchdog_timeout
    |=> !status_flags[4]) else $error("timeout flag not cleared");
  kick_sets_a: assert property (clk_en && watchdog_kick_instr
    && !watchdog_timeout && !sleep_instr |=> status_flags[4:3] == 2'h3)
    else $error("kick did not set flags");
  sleep_flags_a: assert property (clk_en && sleep_instr
    && !watchdog_timeout |=> status_flags[4:3] == 2'h2)
    else $error("sleep flags wrong");
  power_reset_a: assert property (disable iff (1'b0)
    sys_rst && clk_en |=> status_flags == 8'h18)
    else $error("reset value of status wrong");
  soft_keep_a: assert property (clk_en && soft_rst
    |=> $stable(status_flags[2:0])) else $error("flags lost on soft reset");
  add_flags_a: assert property (add_t |=>
    {status_flags[1:0], alu_result_q} == $past(exp_add))
    else $error("add result or carries wrong");
  sub_flags_a: assert property (sub_t |=>
    {status_flags[1:0], alu_result_q} == $past(exp_sub))
    else $error("subtract result or borrows wrong");
  zero_flag_a: assert property (flags_updated_q
    |-> status_flags[2] == (alu_result_q == 8'h00))
    else $error("zero flag wrong");
  update_pulse_a: assert property ((add_t || sub_t)
    |=> flags_updated_q) else $error("no update pulse");
  periph_map_a: assert property (go && bus_wr
    && bus_addr[15:12] == 4'h0 |-> periph_wr == (bus_addr[6:0]
    inside {[7'h0C:7'h1F]}) && (!periph_wr || periph_addr == bus_addr[11:0]))
    else $error("peripheral decode wrong");
  sub_seen_c: cover property (sub_t);
  sleep_seen_c: cover property (clk_en && sleep_instr);
  periph_seen_c: cover property (periph_wr);
endmodule // csfb_status_banks_sva

bind csfb_status_banks csfb_status_banks_sva #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.sys_clk, .sys_rst, .clk_en,
  .soft_rst, .bus_addr, .bus_wr, .alu_op, .alu_a, .alu_b, .alu_result_q,
  .flags_updated_q, .watchdog_kick_instr, .sleep_instr, .watchdog_timeout,
  .status_flags, .periph_addr, .periph_wr);

// [verification/csfb_core_model.sv]
// execution core stand-in: logic results and peripheral read answers
module csfb_core_model (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  alu_a,
  input  wire logic [7:0]  alu_b,
  output logic      [7:0]  alu_logic_result,
  input  wire logic [11:0] periph_addr,
  input  wire logic        periph_rd,
  output logic      [7:0]  periph_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] data_q = 8'h00;
  // logic result handed over for the zero flag
  assign alu_logic_result = alu_a & alu_b;
  // answer one cycle after a read, inverted noise otherwise
  always_ff @(posedge sys_clk) begin
    data_q <= periph_rd ? periph_addr[7:0] ^ 8'h5A : ~data_q;
  end
  assign periph_rdata = data_q;
endmodule // csfb_core_model

// [verification/test_cpu_status_flags_and_banks.sv]
// self-checking bench for the status flags and banked memory block
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module test_cpu_status_flags_and_banks;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        soft_rst = 1'b0;
  logic        clk_en = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  alu_a = 8'h00;
  logic [7:0]  alu_b = 8'h00;
  logic [2:0]  evt = 3'h0;
  csfb_pkg::csfb_alu_op_t alu_op = csfb_pkg::csfb_op_none;
  logic [7:0]  bus_rdata, alu_res, status, alu_lr, periph_rdata, periph_wd;
  logic [4:0]  bank_sel;
  logic [11:0] periph_addr;
  logic        upd, periph_wr, periph_rd;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [1:0]  t_op [8] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [7:0]  t_a [8] = '{8'h0F, 8'hFF, 8'h05, 8'h03, 8'h07, 8'h10, 8'hF0,
                           8'hFF};
  logic [7:0]  t_b [8] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h07, 8'h01, 8'h0F,
                           8'h81};
  logic [7:0]  t_r [8] = '{8'h10, 8'h00, 8'h02, 8'hFE, 8'h00, 8'h0F, 8'h00,
                           8'h81};
  logic [2:0]  t_f [8] = '{3'h2, 3'h7, 3'h3, 3'h0, 3'h7, 3'h1, 3'h5, 3'h1};

  csfb_status_banks dut (.sys_clk, .sys_rst, .clk_en, .soft_rst,
    .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .alu_op, .alu_a,
    .alu_b, .alu_logic_result(alu_lr), .alu_result_q(alu_res),
    .flags_updated_q(upd), .watchdog_kick_instr(evt[0]),
    .sleep_instr(evt[1]), .watchdog_timeout(evt[2]), .status_flags(status),
    .bank_selector_q(bank_sel), .periph_addr, .periph_wdata(periph_wd),
    .periph_wr, .periph_rd, .periph_rdata);
  csfb_core_model core (.sys_clk, .alu_a, .alu_b, .alu_logic_result(alu_lr),
    .periph_addr, .periph_rd, .periph_rdata);

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one bus write cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // one bus read cycle, data checked in the following cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e)
  endtask

  // one cycle of events {timeout, sleep, kick}, then flag check
  task automatic ev(input logic [2:0] e, input logic [1:0] x);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= 3'h0;
    #1;
    `CHK(status[4:3], x)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK(status, 8'h18)
    wr(16'h0003, 8'hFF);
    rd(16'h0003, 8'h1F);
    $display("status access test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      alu_op <= csfb_pkg::csfb_alu_op_t'(t_op[i]);
      alu_a <= t_a[i];
      alu_b <= t_b[i];
      @(posedge sys_clk);
      alu_op <= csfb_pkg::csfb_op_none;
      #1;
      `CHK(alu_res, t_r[i])
      `CHK(status[2:0], t_f[i])
      `CHK(upd, 1'b1)
    end
    // status write in the same cycle as an add
    @(posedge sys_clk);
    alu_op <= csfb_pkg::csfb_op_add;
    alu_a <= 8'hFF;
    alu_b <= 8'h01;
    bus_addr <= 16'h0003;
    bus_wdata <= 8'h00;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    alu_op <= csfb_pkg::csfb_op_none;
    bus_wr <= 1'b0;
    #1;
    `CHK(status[2:0], 3'h7)
    $display("flag test done");
    ev(3'h2, 2'h2);
    ev(3'h4, 2'h0);
    ev(3'h1, 2'h3);
    ev(3'h5, 2'h1);
    wr(16'h0003, 8'hF5);
    wr(16'h0008, 8'hFF);
    #1;
    `CHK(bank_sel, 5'h1F)
    @(posedge sys_clk);
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    #1;
    `CHK(status, 8'h0D)
    `CHK(bank_sel, 5'h00)
    $display("event and soft reset test done");
    rd(16'h0008, 8'h00);
    wr(16'h01A5, 8'hA5);
    rd(16'h20F5, 8'hA5);
    wr(16'h0008, 8'h03);
    rd(16'h1025, 8'hA5);
    wr(16'h29FF, 8'h77);
    rd(16'h0FEF, 8'h77);
    wr(16'h0070, 8'h3C);
    rd(16'h0FF0, 8'h3C);
    rd(16'h1070, 8'h3C);
    rd(16'h010B, 8'h00);
    rd(16'h018C, 8'hD6);
    @(posedge sys_clk);
    bus_addr <= 16'h018C;
    bus_wdata <= 8'h42;
    bus_wr <= 1'b1;
    #1;
    `CHK({periph_wr, periph_addr}, 13'h118C)
    `CHK(periph_wd, 8'h42)
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    wr(16'h0120, 8'h69);
    rd(16'h20A0, 8'h69);
    rd(16'h3000, 8'h00);
    $display("bank map test done");
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(16'h0008, 8'h07);
    #1;
    `CHK(bank_sel, 5'h03)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    $display("clock enable test done");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK(status, 8'h18)
    `CHK(bank_sel, 5'h00)
    $display("power reset test done");
    report_and_stop();
  end
endmodule // test_cpu_status_flags_and_banks
